// >>> dv/strap_board_model.sv
// Board tie-off model that sets the strap pin levels seen by the decoder.
`timescale 1ns/1ps
module strap_board_model (
    input  wire logic [10:0] tie,     // Tie-off levels: mode[10:7], tx, rx, ref, rate, comp.
    input  wire logic [6:0]  dev_out, // Device drive values: mode, ref, rate.
    input  wire logic [2:0]  dev_oe,  // Device drive enables: mode, ref, rate.
    output logic      [10:0] pins     // Resolved pin levels.
);
    // A driving device wins over the weak tie-off resistors.
    always_comb begin
        pins = tie;
        if (dev_oe[0]) begin
            pins[3:2] = dev_out[1:0];
        end
        if (dev_oe[1]) begin
            pins[4] = dev_out[2];
        end
        if (dev_oe[2]) begin
            pins[10:7] = dev_out[6:3];
        end
    end
endmodule : strap_board_model

// >>> dv/testbench.sv
// Self-checking testbench for the strap configuration decoder.
`timescale 1ns/1ps
module testbench;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, tm, ref125, roe, foe, mloe, rout;
    logic [1:0] htrans, pa, lr, lout;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] pll;
    logic [3:0] x1, rxr, txr, mout;
    logic [10:0] tie, pins;
    int err_count, checks, cyc;
    // Clock generation, 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    strap_board_model i_board (.tie(tie), .dev_out({mout, rout, lout}),
        .dev_oe({mloe, foe, roe}), .pins(pins));
    powerup_strap_config_decoder i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .test_mode(tm),
        .comp_mode_strap(pins[1:0]), .lane_rate_strap_in(pins[3:2]), .lane_rate_strap_out(lout),
        .lane_rate_strap_oe(roe), .refclk_rate_strap_in(pins[4]), .refclk_rate_strap_out(rout),
        .refclk_rate_strap_oe(foe), .mac_lane_mode_strap_in(pins[10:7]),
        .mac_lane_mode_strap_out(mout),
        .mac_lane_mode_strap_oe(mloe), .rx_lane_reverse_strap(pins[5]),
        .tx_lane_reverse_strap(pins[6]), .port_arrangement(pa), .lane_rate(lr),
        .refclk_is_125(ref125), .serdes_pll_cfg(pll), .mac_x1_mode(x1),
        .rx_lane_reverse(rxr), .tx_lane_reverse(txr));
    // Compare one value and count it.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Print the verdict and stop.
    task results;
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    // Reset with given ties, then flip the ties to prove they are held.
    task do_reset(input logic [10:0] t);
        tie <= t;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        tie <= ~t;
        repeat (3) @(posedge clk);
    endtask : do_reset
    // Single AHB-Lite word transfer; waits for hready in both phases.
    // Select stays high between calls: an IDLE htrans keeps the slave quiet,
    // and a back-to-back call never flips it twice in one time step.
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    // Hang guard: ceiling well above the roughly 90 cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        err_count = 0;
        checks    = 0;
        cyc       = 0;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = 2'h0;
        hwrite    = 1'b0;
        hsize     = strap_cfg_pkg::HSIZE_WORD;
        hwdata    = 32'h0;
        tm        = 1'b0;
        // Native arrangement, 2.5G, 125 MHz ref, rx reversed.
        do_reset(11'h036);
        chk(pa, strap_cfg_pkg::COMP_NATIVE);
        chk(lr, strap_cfg_pkg::RATE_2G5);
        chk({ref125, pll}, {1'b1, strap_cfg_pkg::PLL_CFG_125});
        chk({x1, rxr, txr}, 12'h0F0);
        chk({roe, foe, mloe}, 3'h0);
        ahb(1'b0, 8'h00, 32'h0);
        chk({hresp, rd[1:0]}, {1'b0, strap_cfg_pkg::RATE_2G5});
        ahb(1'b1, 8'h04, 32'h20);
        ahb(1'b1, 8'h08, 32'h330);
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd & 32'h13F, 32'h131);
        chk({x1, rxr, txr}, 12'h492);
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        tm <= 1'b1;
        repeat (3) @(posedge clk);
        chk({roe, foe, mloe, lout, rout, mout}, {3'h7, 2'h1, 1'b1, 4'h0});
        tm <= 1'b0;
        // Sixteen single-lane ports, slowest rate, 156.25 MHz ref, swaps ignored.
        do_reset(11'h060);
        chk({pa, lr, pll}, {4'h0, strap_cfg_pkg::PLL_CFG_156});
        chk({x1, rxr, txr}, 12'hF00);
        // Mixed arrangement at the default rate.
        do_reset(11'h069);
        chk({pa, lr}, 4'h6);
        chk({x1, rxr, txr}, 12'hC33);
        // Reserved select acts as native, illegal rate falls back, MAC0 taken over.
        do_reset(11'h2CF);
        chk({pa, lr}, 4'hE);
        chk({x1, rxr, txr}, 12'h50A);
        ahb(1'b0, strap_cfg_pkg::STATUS_OFS, 32'h0);
        chk(rd, 32'h1B);
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd & 32'h33F, 32'h122);
        ahb(1'b1, 8'h00, 32'h210);
        ahb(1'b0, 8'h00, 32'h0);
        chk(rd & 32'h33F, 32'h212);
        chk({x1, rxr, txr}, 12'h41A);
        results();
    end
endmodule : testbench

// >>> logic/powerup_strap_config_decoder.sv
// Strap decoder with AHB-Lite register slave for per-MAC overrides.
`timescale 1ns/1ps
module powerup_strap_config_decoder (
    input  wire logic        clk,                    // Reference clock, 100 MHz.
    input  wire logic        rst,                    // Synchronous reset, active high.
    input  wire logic        hsel,                   // AHB slave select.
    input  wire logic [31:0] haddr,                  // AHB address.
    input  wire logic [1:0]  htrans,                 // AHB transfer type.
    input  wire logic        hwrite,                 // AHB write.
    input  wire logic [2:0]  hsize,                  // AHB size.
    input  wire logic [31:0] hwdata,                 // AHB write data.
    input  wire logic        hready,                 // AHB bus ready.
    output logic             hreadyout,              // AHB slave ready.
    output logic             hresp,                  // AHB response, always OKAY.
    output logic      [31:0] hrdata,                 // AHB read data.
    input  wire logic        test_mode,              // Test mode, allows strap drive.
    input  wire logic [1:0]  comp_mode_strap,        // Compatibility select pins.
    input  wire logic [1:0]  lane_rate_strap_in,     // Lane rate strap level.
    output logic      [1:0]  lane_rate_strap_out,    // Lane rate strap drive value.
    output logic             lane_rate_strap_oe,     // Lane rate strap drive enable.
    input  wire logic        refclk_rate_strap_in,   // Reference rate strap level.
    output logic             refclk_rate_strap_out,  // Reference rate drive value.
    output logic             refclk_rate_strap_oe,   // Reference rate drive enable.
    input  wire logic [3:0]  mac_lane_mode_strap_in, // Per-MAC lane mode strap level.
    output logic      [3:0]  mac_lane_mode_strap_out,// Lane mode drive value.
    output logic             mac_lane_mode_strap_oe, // Lane mode drive enable.
    input  wire logic        rx_lane_reverse_strap,  // Receive lane order strap.
    input  wire logic        tx_lane_reverse_strap,  // Transmit lane order strap.
    output logic      [1:0]  port_arrangement,       // Decoded compatibility select.
    output logic      [1:0]  lane_rate,              // Rate for all serial ports.
    output logic             refclk_is_125,          // Reference clock is 125 MHz.
    output logic      [7:0]  serdes_pll_cfg,         // SerDes PLL setting.
    output logic      [3:0]  mac_x1_mode,            // Per MAC, 1 means single-lane.
    output logic      [3:0]  rx_lane_reverse,        // Per MAC receive order reversed.
    output logic      [3:0]  tx_lane_reverse         // Per MAC transmit order reversed.
);

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [strap_cfg_pkg::CAP_W-1:0] cap;      // Held strap vector.
    logic [1:0]                      cap_comp; // Held compatibility select.
    logic [1:0]                      cap_rate; // Held lane rate.
    logic [3:0]                      cap_mode; // Held lane mode straps.

    strap_capture #(.W(strap_cfg_pkg::CAP_W)) u_capture (
        .clk  (clk),
        .rst  (rst),
        .pins ({mac_lane_mode_strap_in, tx_lane_reverse_strap, rx_lane_reverse_strap,
                refclk_rate_strap_in, lane_rate_strap_in, comp_mode_strap}),
        .cap  (cap)
    );

    assign cap_comp = cap[strap_cfg_pkg::CAP_COMP_LSB +: 2];
    assign cap_rate = cap[strap_cfg_pkg::CAP_RATE_LSB +: 2];
    assign cap_mode = cap[strap_cfg_pkg::CAP_MODE_LSB +: 4];

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // True when a byte address selects the register of MAC i.
    function automatic logic mac_hit(input logic [7:0] addr, input int i);
        logic [7:0] ofs;
        ofs = strap_cfg_pkg::MAC_CFG_BASE + 8'(i) * strap_cfg_pkg::MAC_CFG_STEP;
        return addr == ofs;
    endfunction : mac_hit

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    strap_cfg_pkg::bus_state_t state;    // Read wait-state tracker.
    logic                      acc;      // Address phase taken this edge.
    logic                      wr_pend;  // Write data phase under way.
    logic [7:0]                wr_addr;  // Address of pending write.
    logic [7:0]                rd_addr;  // Address of pending read.
    logic [31:0]               rd_word;  // Read value for rd_addr.

    assign acc = hsel && htrans[1] && hready && (hsize == strap_cfg_pkg::HSIZE_WORD);

    // Reads take one wait state, so a read right behind a write to the same
    // register always sees the new value without any forwarding path.
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= strap_cfg_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
        end else begin
            case (state)
                strap_cfg_pkg::BUS_IDLE: begin
                    // A read holds the bus for one extra cycle.
                    if (acc && !hwrite) begin
                        state     <= strap_cfg_pkg::BUS_WAIT;
                        hreadyout <= 1'b0;
                    end
                end
                strap_cfg_pkg::BUS_WAIT: begin
                    state     <= strap_cfg_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    state     <= strap_cfg_pkg::BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Address phase capture for writes and reads.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pend <= acc && hwrite;
            if (acc) begin
                wr_addr <= haddr[7:0];
                rd_addr <= haddr[7:0];
            end
        end
    end

    // Read data is loaded in the wait state and then held.
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= strap_cfg_pkg::RDATA_RST;
            hresp  <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (state == strap_cfg_pkg::BUS_WAIT) begin
                hrdata <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Override registers
    // ------------------------------------------------------------------
    logic [3:0] rx_val;   // Written receive reverse value.
    logic [3:0] rx_set;   // Receive field written since reset.
    logic [3:0] tx_val;   // Written transmit reverse value.
    logic [3:0] tx_set;   // Transmit field written since reset.
    logic [3:0] mode_val; // Written lane mode value.
    logic [3:0] mode_ovr; // Lane mode field in force.

    // Any write to a MAC register takes both swap fields into software hands.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_val   <= 4'h0;
            rx_set   <= 4'h0;
            tx_val   <= 4'h0;
            tx_set   <= 4'h0;
            mode_val <= 4'h0;
            mode_ovr <= 4'h0;
        end else if (wr_pend) begin
            for (int i = 0; i < strap_cfg_pkg::NUM_MAC; i++) begin
                if (mac_hit(wr_addr, i)) begin
                    rx_val[i]   <= hwdata[strap_cfg_pkg::RX_SWAP_BIT];
                    rx_set[i]   <= 1'b1;
                    tx_val[i]   <= hwdata[strap_cfg_pkg::TX_SWAP_BIT];
                    tx_set[i]   <= 1'b1;
                    mode_val[i] <= hwdata[strap_cfg_pkg::MODE_BIT];
                    mode_ovr[i] <= hwdata[strap_cfg_pkg::MODE_OVR_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    logic [1:0] next_rate; // Rate used by all ports.
    logic [3:0] next_x1;   // Effective lane mode per MAC.
    logic [3:0] sw_rx;     // Receive reverse request per MAC.
    logic [3:0] sw_tx;     // Transmit reverse request per MAC.

    always_comb begin
        // An illegal rate strap falls back to the default rate.
        next_rate = (cap_rate == strap_cfg_pkg::RATE_ILLEGAL) ? strap_cfg_pkg::RATE_3G125
                                                               : cap_rate;
        case (cap_comp)
            strap_cfg_pkg::COMP_X1_ALL: next_x1 = strap_cfg_pkg::ALL_X1;
            strap_cfg_pkg::COMP_MIXED:  next_x1 = strap_cfg_pkg::MIXED_X1;
            // Native and reserved both use the native arrangement.
            default: next_x1 = (mode_ovr & mode_val) | (~mode_ovr & cap_mode);
        endcase
        sw_rx = (rx_set & rx_val) | (~rx_set & {4{cap[strap_cfg_pkg::CAP_RX_BIT]}});
        sw_tx = (tx_set & tx_val) | (~tx_set & {4{cap[strap_cfg_pkg::CAP_TX_BIT]}});
    end

    // Register read mux; unmapped addresses read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int i = 0; i < strap_cfg_pkg::NUM_MAC; i++) begin
            if (mac_hit(rd_addr, i)) begin
                rd_word[strap_cfg_pkg::RATE_LSB +: 2]    = next_rate;
                rd_word[strap_cfg_pkg::RX_SWAP_BIT]      = sw_rx[i];
                rd_word[strap_cfg_pkg::TX_SWAP_BIT]      = sw_tx[i];
                rd_word[strap_cfg_pkg::MODE_BIT]         = next_x1[i];
                rd_word[strap_cfg_pkg::MODE_OVR_BIT]     = mode_ovr[i];
            end
        end
        if (rd_addr == strap_cfg_pkg::STATUS_OFS) begin
            rd_word[strap_cfg_pkg::ST_COMP_LSB +: 2] = cap_comp;
            rd_word[strap_cfg_pkg::ST_REF_BIT]       = cap[strap_cfg_pkg::CAP_REF_BIT];
            rd_word[strap_cfg_pkg::ST_ILL_BIT]       = cap_rate == strap_cfg_pkg::RATE_ILLEGAL;
            rd_word[strap_cfg_pkg::ST_RSV_BIT]       = cap_comp == strap_cfg_pkg::COMP_RSVD;
        end
    end

    // Registered configuration outputs; swaps are masked in single-lane mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            port_arrangement <= strap_cfg_pkg::COMP_NATIVE;
            lane_rate        <= strap_cfg_pkg::RATE_3G125;
            refclk_is_125    <= 1'b0;
            serdes_pll_cfg   <= strap_cfg_pkg::PLL_CFG_156;
            mac_x1_mode      <= 4'h0;
            rx_lane_reverse  <= 4'h0;
            tx_lane_reverse  <= 4'h0;
        end else begin
            port_arrangement <= cap_comp;
            lane_rate        <= next_rate;
            refclk_is_125    <= cap[strap_cfg_pkg::CAP_REF_BIT];
            serdes_pll_cfg   <= cap[strap_cfg_pkg::CAP_REF_BIT] ? strap_cfg_pkg::PLL_CFG_125
                                                                : strap_cfg_pkg::PLL_CFG_156;
            mac_x1_mode      <= next_x1;
            rx_lane_reverse  <= sw_rx & ~next_x1;
            tx_lane_reverse  <= sw_tx & ~next_x1;
        end
    end

    // ------------------------------------------------------------------
    // Strap pin drivers
    // ------------------------------------------------------------------
    // The drivers echo the held straps so a tester can read them back.
    always_ff @(posedge clk) begin
        if (rst) begin
            lane_rate_strap_oe      <= 1'b0;
            refclk_rate_strap_oe    <= 1'b0;
            mac_lane_mode_strap_oe  <= 1'b0;
            lane_rate_strap_out     <= 2'h0;
            refclk_rate_strap_out   <= 1'b0;
            mac_lane_mode_strap_out <= 4'h0;
        end else begin
            lane_rate_strap_oe      <= test_mode;
            refclk_rate_strap_oe    <= test_mode;
            mac_lane_mode_strap_oe  <= test_mode;
            lane_rate_strap_out     <= cap_rate;
            refclk_rate_strap_out   <= cap[strap_cfg_pkg::CAP_REF_BIT];
            mac_lane_mode_strap_out <= cap_mode;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_drive_test;
        @(posedge clk) disable iff (rst)
            (lane_rate_strap_oe || refclk_rate_strap_oe || mac_lane_mode_strap_oe)
            |-> $past(test_mode);
    endproperty
    a_drive_test: assert property (p_drive_test)
        else $error("Strap pin driven outside test mode.");

    // The sampled reset term keeps the release edge out of the checks below:
    // at that edge the outputs still carry their reset values.
    property p_comp_x1;
        @(posedge clk) disable iff (rst)
            (!rst && cap_comp == strap_cfg_pkg::COMP_X1_ALL)
            |=> mac_x1_mode == strap_cfg_pkg::ALL_X1;
    endproperty
    a_comp_x1: assert property (p_comp_x1)
        else $error("Single-lane arrangement not applied.");

    property p_comp_mixed;
        @(posedge clk) disable iff (rst)
            (!rst && cap_comp == strap_cfg_pkg::COMP_MIXED)
            |=> mac_x1_mode == strap_cfg_pkg::MIXED_X1;
    endproperty
    a_comp_mixed: assert property (p_comp_mixed)
        else $error("Mixed arrangement not applied.");

    property p_native;
        @(posedge clk) disable iff (rst)
            (!rst && cap_comp[1] && mode_ovr == 4'h0) |=> mac_x1_mode == $past(cap_mode);
    endproperty
    a_native: assert property (p_native)
        else $error("Native arrangement does not follow lane mode straps.");

    property p_rate;
        @(posedge clk) disable iff (rst)
            (!rst && cap_rate != strap_cfg_pkg::RATE_ILLEGAL) |=> lane_rate == $past(cap_rate);
    endproperty
    a_rate: assert property (p_rate)
        else $error("Lane rate differs from strap.");

    sequence s_rd_mac0;
        acc && !hwrite && mac_hit(haddr[7:0], 0);
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 (hreadyout && hrdata[1:0] == lane_rate);
    endsequence
    property p_rd_rate;
        @(posedge clk) disable iff (rst) s_rd_mac0 |=> s_rd_answer;
    endproperty
    a_rd_rate: assert property (p_rd_rate)
        else $error("Rate field read does not match strapped rate.");

    property p_pll;
        @(posedge clk) disable iff (rst)
            !rst |=> serdes_pll_cfg == ($past(cap[strap_cfg_pkg::CAP_REF_BIT])
                     ? strap_cfg_pkg::PLL_CFG_125 : strap_cfg_pkg::PLL_CFG_156);
    endproperty
    a_pll: assert property (p_pll)
        else $error("PLL setting does not match reference clock strap.");

    property p_swap_strap;
        @(posedge clk) disable iff (rst)
            (!rst && !rx_set[0]) |=> rx_lane_reverse[0] ==
                           ($past(cap[strap_cfg_pkg::CAP_RX_BIT]) && !mac_x1_mode[0]);
    endproperty
    a_swap_strap: assert property (p_swap_strap)
        else $error("Receive lane order does not follow strap.");

    sequence s_wr_swap0;
        acc && hwrite && mac_hit(haddr[7:0], 0) ##1 hwdata[strap_cfg_pkg::RX_SWAP_BIT];
    endsequence
    property p_swap_ovr;
        @(posedge clk) disable iff (rst)
            // The field loads at the data edge; the output follows one edge later.
            s_wr_swap0 |=> ##1 rx_lane_reverse[0] == !mac_x1_mode[0];
    endproperty
    a_swap_ovr: assert property (p_swap_ovr)
        else $error("Written receive swap did not take over.");

    property p_x1_noswap;
        @(posedge clk) disable iff (rst)
            ((rx_lane_reverse | tx_lane_reverse) & mac_x1_mode) == 4'h0;
    endproperty
    a_x1_noswap: assert property (p_x1_noswap)
        else $error("Lane reverse active in single-lane mode.");

    property p_mode_ovr;
        @(posedge clk) disable iff (rst)
            (cap_comp[1] && mode_ovr[0]) |=> mac_x1_mode[0] == $past(mode_val[0]);
    endproperty
    a_mode_ovr: assert property (p_mode_ovr)
        else $error("Lane mode field did not override strap.");

endmodule : powerup_strap_config_decoder

// >>> logic/strap_capture.sv
// Strap sampler that follows the pins during reset and holds afterwards.
`timescale 1ns/1ps
module strap_capture #(
    parameter int W = 11
) (
    input  wire logic         clk,  // Reference clock.
    input  wire logic         rst,  // Synchronous reset, active high.
    input  wire logic [W-1:0] pins, // Strap levels from the board.
    output logic      [W-1:0] cap   // Held strap values.
);

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // The pins are tracked at every edge while reset is high, so the value
    // seen at the last reset edge is kept. Board tie-offs must be settled
    // before reset falls; a late strap change is never seen.
    always_ff @(posedge clk) begin
        if (rst) begin
            cap <= pins;
        end
    end

    // Captured straps never move once reset has gone away.
    property p_cap_hold;
        @(posedge clk) disable iff (rst) !$past(rst) |-> $stable(cap);
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("Captured straps changed outside reset.");

endmodule : strap_capture

// >>> logic/strap_cfg_pkg.sv
// Constants and types shared by the strap configuration decoder files.
// Contract
// - Lane rate strap sets every port rate.
// - Register rate field reads back strapped rate.
// - Reference clock strap picks SerDes PLL settings.
// - Strap pins drive out only in test mode.
// - Swap straps reverse four-lane lane order.
// - Written register swap fields override swap straps.
// - Lane swap ignored for single-lane ports.
// - Lane mode strap per MAC, field overrides. Both are used only in the native and reserved arrangements.
package strap_cfg_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned word each).
    // ------------------------------------------------------------------
    localparam logic [7:0] MAC_CFG_BASE = 8'h00; // MAC i sits at base + 4*i.
    localparam logic [7:0] MAC_CFG_STEP = 8'h04; // Spacing of MAC registers.
    localparam logic [7:0] STATUS_OFS   = 8'h10; // Captured strap status.
    localparam int         NUM_MAC      = 4;     // MACs with four lanes each.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int RATE_LSB     = 0; // Lane rate field, two bits, read only.
    localparam int RX_SWAP_BIT  = 4; // Receive lane reverse.
    localparam int TX_SWAP_BIT  = 5; // Transmit lane reverse.
    localparam int MODE_BIT     = 8; // Lane mode field value, 1 means single-lane.
    localparam int MODE_OVR_BIT = 9; // Lane mode field takes over from the strap.
    localparam int ST_COMP_LSB  = 0; // Status: captured compatibility select.
    localparam int ST_REF_BIT   = 2; // Status: reference clock is 125 MHz.
    localparam int ST_ILL_BIT   = 3; // Status: illegal lane rate strapped.
    localparam int ST_RSV_BIT   = 4; // Status: reserved compatibility strapped.

    // ------------------------------------------------------------------
    // Layout of the captured strap vector.
    // ------------------------------------------------------------------
    localparam int CAP_COMP_LSB = 0;
    localparam int CAP_RATE_LSB = 2;
    localparam int CAP_REF_BIT  = 4;
    localparam int CAP_RX_BIT   = 5;
    localparam int CAP_TX_BIT   = 6;
    localparam int CAP_MODE_LSB = 7;
    localparam int CAP_W        = 11;

    // ------------------------------------------------------------------
    // Encodings and reset values.
    // ------------------------------------------------------------------
    localparam logic [1:0] COMP_X1_ALL  = 2'h0; // Sixteen single-lane ports.
    localparam logic [1:0] COMP_MIXED   = 2'h1; // Two four-lane plus eight single.
    localparam logic [1:0] COMP_NATIVE  = 2'h2; // Native arrangement, default.
    localparam logic [1:0] COMP_RSVD    = 2'h3; // Reserved.
    localparam logic [1:0] RATE_1G25    = 2'h0; // 1.25 Gbit/s.
    localparam logic [1:0] RATE_2G5     = 2'h1; // 2.5 Gbit/s.
    localparam logic [1:0] RATE_3G125   = 2'h2; // 3.125 Gbit/s, default.
    localparam logic [1:0] RATE_ILLEGAL = 2'h3; // Must never be strapped.
    localparam logic [7:0] PLL_CFG_125  = 8'h19; // PLL setting, 125 MHz reference.
    localparam logic [7:0] PLL_CFG_156  = 8'h14; // PLL setting, 156.25 MHz reference.
    localparam logic [2:0] HSIZE_WORD   = 3'h2;  // Only whole-word transfers.
    localparam logic [3:0] ALL_X1       = 4'hF;  // Every MAC in single-lane mode.
    localparam logic [3:0] MIXED_X1     = 4'hC;  // Upper two MACs single-lane.
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // Bus slave state, a one-bit Gray sequence.
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_WAIT = 1'b1
    } bus_state_t;

endpackage : strap_cfg_pkg
